// >>> glr_receiver.sv
`timescale 1ns/1ps
`default_nettype none
// Listener receive engine: takes talker bytes through an acceptor
// handshake and writes the stored string into a byte memory.
module glr_receiver #(
  parameter int DEPTH = 256,
  parameter int TIMEOUT = glr_pkg::TIMEOUT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Receive request from host software
  input wire logic STRING_RECEIVE_REQUEST,
  input wire logic [glr_pkg::LEN_W-1:0] MAX_LEN,
  input wire logic TERM_SEL_VALID,
  input wire logic [1:0] TERM_SEL,
  input wire logic LISTENER_ADDRESSED,
  // Terminator slot write
  input wire logic INPUT_TERMINATOR_SETUP,
  input wire logic [1:0] TERM_SLOT,
  input wire logic [7:0] TERM_CHAR,
  // Talker side, asynchronous pins
  input wire logic [7:0] BUS_DATA,
  input wire logic BUS_DAV,
  input wire logic BUS_EOI,
  output logic BUS_NRFD,
  output logic BUS_NDAC,
  // Result
  output logic DONE,
  output logic BUSY,
  output logic [glr_pkg::LEN_W-1:0] RESULT_LEN,
  output logic [7:0] STATUS,
  // Buffer read port
  input wire logic [glr_pkg::LEN_W-1:0] RD_ADDR,
  output logic [7:0] RD_DATA
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [9:0] pin_s;
  glr_sync #(.W(10)) u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .d({BUS_EOI, BUS_DAV, BUS_DATA}),
    .q(pin_s)
  );
  logic dav_s, eoi_s;
  logic [7:0] data_s;
  assign dav_s = pin_s[8];
  assign eoi_s = pin_s[9];
  assign data_s = pin_s[7:0];

  // ----------------------------------------
  // Terminator slots
  // ----------------------------------------
  logic [7:0] term_q [4];
  logic [7:0] term_d [4];
  localparam logic [7:0] TERM_RST [4] = '{glr_pkg::TERM0_RST,
    glr_pkg::TERM1_RST, glr_pkg::TERM2_RST, glr_pkg::TERM3_RST};
  always_comb begin
    term_d = term_q;
    if (INPUT_TERMINATOR_SETUP) begin
      term_d[TERM_SLOT] = TERM_CHAR;
    end
  end
  for (genvar i = 0; i < 4; i++) begin : g_term
    always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
        term_q[i] <= TERM_RST[i];
      end else begin
        term_q[i] <= term_d[i];
      end
    end
  end

  // ----------------------------------------
  // Acceptor handshake, byte capture
  // ----------------------------------------
  // Byte and EOI travel together so a stalled store loses nothing.
  logic hs_valid, hs_ready, st_valid, st_ready;
  logic [8:0] st_data;
  logic hs_q, hs_d; // 1 = byte taken, waiting for DAV release
  logic listen_q, listen_d;
  glr_pkg::glr_state_t st_q, st_d;
  always_comb begin
    hs_d = hs_q;
    hs_valid = 1'b0;
    if (!hs_q) begin
      if (dav_s && hs_ready && listen_q) begin
        hs_valid = 1'b1;
        hs_d = 1'b1;
      end
    end else if (!dav_s) begin
      hs_d = 1'b0;
    end
  end
  glr_buf2 #(.W(9)) u_buf (
    .clk(CLK_SYS),
    .rst(RESET),
    .in_valid(hs_valid),
    .in_ready(hs_ready),
    .in_data({eoi_s, data_s}),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_data)
  );

  // ----------------------------------------
  // Receive control
  // ----------------------------------------
  logic [7:0] mem [DEPTH];
  logic [glr_pkg::LEN_W-1:0] cnt_q, cnt_d, max_q, max_d;
  logic [7:0] term_chr_q, term_chr_d;
  logic [2:0] stat_q, stat_d; // timeout, overflow, not listener
  logic [glr_pkg::TIMEOUT_W-1:0] wait_q, wait_d;
  logic done_q, done_d;
  logic wr_en;
  logic [glr_pkg::LEN_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic is_term, is_cr, is_eoi;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    max_d = max_q;
    term_chr_d = term_chr_q;
    stat_d = stat_q;
    wait_d = wait_q;
    done_d = 1'b0;
    listen_d = 1'b0;
    st_ready = 1'b0;
    wr_en = 1'b0;
    wr_addr = cnt_q;
    wr_data = st_data[7:0];
    is_eoi = st_data[8];
    is_term = (st_data[7:0] == term_chr_q);
    is_cr = (st_data[7:0] == glr_pkg::CR_CHAR);
    unique case (st_q)
      glr_pkg::ST_IDLE: begin
        st_ready = 1'b1; // Flush stale bytes
        if (STRING_RECEIVE_REQUEST) begin
          cnt_d = '0;
          max_d = MAX_LEN;
          wait_d = '0;
          term_chr_d = TERM_SEL_VALID ? term_q[TERM_SEL] : term_q[0];
          if (!LISTENER_ADDRESSED) begin
            stat_d = 3'b001;
            st_d = glr_pkg::ST_NULL;
          end else begin
            stat_d = 3'b000;
            st_d = (MAX_LEN == '0) ? glr_pkg::ST_NULL : glr_pkg::ST_RUN;
          end
        end
      end
      glr_pkg::ST_RUN: begin
        listen_d = 1'b1;
        st_ready = 1'b1;
        wait_d = wait_q + 1'b1;
        if (st_valid) begin
          wait_d = '0;
          if (!(is_cr || is_term)) begin
            wr_en = 1'b1;
            cnt_d = cnt_q + 1'b1;
          end
          if (is_term || is_eoi) begin
            st_d = glr_pkg::ST_NULL;
            listen_d = 1'b0;
          end else if (!(is_cr || is_term) && cnt_q + 1'b1 == max_q) begin
            stat_d[1] = 1'b1;
            st_d = glr_pkg::ST_NULL;
            listen_d = 1'b0;
          end
        end else if (wait_q >= TIMEOUT - 1) begin
          stat_d[2] = 1'b1;
          st_d = glr_pkg::ST_NULL;
          listen_d = 1'b0;
        end
      end
      glr_pkg::ST_NULL: begin
        wr_en = 1'b1;
        wr_data = glr_pkg::NULL_CHAR;
        st_d = glr_pkg::ST_DONE;
      end
      glr_pkg::ST_DONE: begin
        done_d = 1'b1;
        st_d = glr_pkg::ST_IDLE;
      end
      default: st_d = glr_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (wr_en) begin
      mem[wr_addr[$clog2(DEPTH)-1:0]] <= wr_data;
    end
  end
  logic [7:0] rd_q;
  always_ff @(posedge CLK_SYS) begin
    rd_q <= mem[RD_ADDR[$clog2(DEPTH)-1:0]];
  end
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_q <= glr_pkg::ST_IDLE;
      cnt_q <= '0;
      max_q <= '0;
      term_chr_q <= glr_pkg::TERM0_RST;
      stat_q <= 3'b000;
      wait_q <= '0;
      done_q <= 1'b0;
      hs_q <= 1'b0;
      listen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      max_q <= max_d;
      term_chr_q <= term_chr_d;
      stat_q <= stat_d;
      wait_q <= wait_d;
      done_q <= done_d;
      hs_q <= hs_d;
      listen_q <= listen_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic nrfd_q, ndac_q, busy_q;
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      nrfd_q <= 1'b1;
      ndac_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      nrfd_q <= !(listen_d && hs_ready && !hs_d);
      ndac_q <= !hs_d;
      busy_q <= (st_d != glr_pkg::ST_IDLE);
    end
  end
  assign BUS_NRFD = nrfd_q;
  assign BUS_NDAC = ndac_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign RESULT_LEN = cnt_q;
  assign STATUS = {4'h0, stat_q[2], stat_q[1], stat_q[0], 1'b0};
  assign RD_DATA = rd_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence req_not_listen_s;
    STRING_RECEIVE_REQUEST && !LISTENER_ADDRESSED && st_q == glr_pkg::ST_IDLE;
  endsequence
  sequence finish_s;
    ##3 DONE;
  endsequence
  sequence close_s;
    st_q == glr_pkg::ST_NULL ##1 st_q == glr_pkg::ST_DONE ##1 DONE;
  endsequence
  listen_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    req_not_listen_s |-> finish_s ##0 STATUS[glr_pkg::STAT_NOT_LISTEN_BIT])
    else $error("not listener flag missing");
  len_limit_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_q == glr_pkg::ST_RUN |-> cnt_q < max_q)
    else $error("count passed maximum");
  full_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    DONE && STATUS[glr_pkg::STAT_OVERFLOW_BIT] |-> RESULT_LEN == max_q)
    else $error("overflow without full buffer");
  cr_drop_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_q == glr_pkg::ST_RUN && st_valid && (is_cr || is_term)
    |=> cnt_q == $past(cnt_q))
    else $error("discarded byte was counted");
  term_end_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_q == glr_pkg::ST_RUN && st_valid && is_term
    |=> st_q == glr_pkg::ST_NULL ##1 st_q == glr_pkg::ST_DONE)
    else $error("terminator did not end reception");
  eoi_end_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_q == glr_pkg::ST_RUN && st_valid && is_eoi |=> close_s)
    else $error("EOI did not end reception");
  expiry_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    DONE && STATUS[glr_pkg::STAT_TIMEOUT_BIT]
    |-> $past(wait_q, 2) >= TIMEOUT - 1)
    else $error("timeout flag without expiry");
  stat_zero_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $onehot0(stat_q) && STATUS[7:4] == 4'h0 && !STATUS[0])
    else $error("reserved status bits set");
  null_wr_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_q == glr_pkg::ST_NULL |-> wr_en && wr_data == glr_pkg::NULL_CHAR
    && wr_addr == cnt_q)
    else $error("null byte not written after data");
endmodule // glr_receiver
`default_nettype wire

// >>> glr_pkg.sv
package glr_pkg;
  localparam int LEN_W = 16;
  localparam logic [7:0] TERM0_RST = 8'h0A;
  localparam logic [7:0] TERM1_RST = 8'h0D;
  localparam logic [7:0] TERM2_RST = 8'h2C;
  localparam logic [7:0] TERM3_RST = 8'h3B;
  localparam logic [7:0] CR_CHAR = 8'h0D;
  localparam logic [7:0] NULL_CHAR = 8'h00;
  localparam int STAT_TIMEOUT_BIT = 3;
  localparam int STAT_OVERFLOW_BIT = 2;
  localparam int STAT_NOT_LISTEN_BIT = 1;
  localparam int TIMEOUT_US = 10000;
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TIMEOUT_W = 32;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_NULL, ST_DONE
  } glr_state_t;
endpackage

// >>> glr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module glr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule // glr_sync
`default_nettype wire

// >>> glr_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module glr_buf2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // ----------------------------------------
  // Two-entry buffer
  // ----------------------------------------
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic push, pop;
  always_comb begin
    push = in_valid && (cnt_q != 2'h2);
    pop = out_ready && (cnt_q != 2'h0);
    mem_d = mem_q;
    if (push) begin
      mem_d[wp_q] = in_data;
    end
    wp_d = wp_q ^ push;
    rp_d = rp_q ^ pop;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
endmodule // glr_buf2
`default_nettype wire

// >>> glr_talker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Talker model: three-wire source handshake
// ----------------------------------------
module glr_talker (
  input wire logic clk,
  input wire logic nrfd,
  input wire logic ndac,
  input wire logic [1:0] gap,
  output logic [7:0] data,
  output logic dav,
  output logic eoi
);
  logic [8:0] q [$];
  initial begin
    dav = 1'b0;
    eoi = 1'b0;
    data = 8'hA5;
    forever begin
      @(posedge clk);
      if (q.size() != 0 && !nrfd) begin
        repeat (gap) @(posedge clk);
        data <= q[0][7:0];
        eoi <= q[0][8];
        // Data settles a full cycle before valid is raised
        @(posedge clk);
        dav <= 1'b1;
        while (ndac) @(posedge clk);
        dav <= 1'b0;
        eoi <= 1'b0;
        void'(q.pop_front());
        while (!ndac) @(posedge clk);
      end else begin
        // Released lines keep moving so stale data never looks valid
        data <= ~data;
      end
    end
  end
endmodule // glr_talker
`default_nettype wire

// >>> gpib_listener_string_receive_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_listener_string_receive_tb;
  logic clk, rst, req, tsv, lis, tset, dav, eoi, nrfd, ndac, done, busy;
  logic [15:0] maxl, rlen, raddr;
  logic [1:0] tsel, tslot, gap;
  logic [7:0] tchar, bdata, stat, rdata;
  logic [7:0] term_tab [4];
  logic [8:0] strm [$];
  logic [7:0] exp_q [$];
  int mismatches = 0;
  int n_tests = 0;
  int seed = 67228;
  int cyc = 0;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  glr_receiver #(.TIMEOUT(50)) i_glr_receiver (
    .CLK_SYS(clk), .RESET(rst), .STRING_RECEIVE_REQUEST(req),
    .MAX_LEN(maxl), .TERM_SEL_VALID(tsv), .TERM_SEL(tsel),
    .LISTENER_ADDRESSED(lis), .INPUT_TERMINATOR_SETUP(tset),
    .TERM_SLOT(tslot), .TERM_CHAR(tchar), .BUS_DATA(bdata),
    .BUS_DAV(dav), .BUS_EOI(eoi), .BUS_NRFD(nrfd), .BUS_NDAC(ndac),
    .DONE(done), .BUSY(busy), .RESULT_LEN(rlen), .STATUS(stat),
    .RD_ADDR(raddr), .RD_DATA(rdata));

  glr_talker i_glr_talker (.clk(clk), .nrfd(nrfd), .ndac(ndac),
    .gap(gap), .data(bdata), .dav(dav), .eoi(eoi));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------
  // Expectation and stimulus
  // ----------------------------------------
  // Stops at the first ending byte; a dry stream means a timeout
  task automatic model(input logic [7:0] t, input int ml, output int used,
                       output logic [7:0] st);
    logic [7:0] b;
    exp_q = {};
    st = 8'h08;
    used = strm.size();
    for (int i = 0; i < strm.size(); i++) begin
      b = strm[i][7:0];
      if (b != t && b != 8'h0D) exp_q.push_back(b);
      if (b == t || strm[i][8]) begin
        used = i + 1;
        st = 8'h00;
        break;
      end
      if (exp_q.size() == ml) begin
        used = i + 1;
        st = 8'h04;
        break;
      end
    end
  endtask

  task automatic gen(input int n);
    logic [8:0] r;
    strm = {};
    repeat (n) begin
      r = 9'($random(seed));
      if (r[6:4] == 3'h0) r[7:0] = term_tab[r[1:0]];
      if (r[6:4] == 3'h1) r[7:0] = 8'h0D;
      r[8] = ($random(seed) & 7) == 0;
      strm.push_back(r);
    end
  endtask

  task automatic set_term(input logic [1:0] s, input logic [7:0] c);
    @(posedge clk);
    tset <= 1'b1;
    tslot <= s;
    tchar <= c;
    term_tab[s] = c;
    @(posedge clk);
    tset <= 1'b0;
  endtask

  task automatic run(input logic sv, input logic [1:0] sl, input logic l,
                     input int ml);
    int used;
    logic [7:0] st;
    model(term_tab[sv ? sl : 2'd0], ml, used, st);
    if (!l || ml == 0) begin
      used = 0;
      st = l ? 8'h00 : 8'h02;
      exp_q = {};
    end
    while (strm.size() > used) void'(strm.pop_back());
    i_glr_talker.q = strm;
    @(posedge clk);
    req <= 1'b1;
    tsv <= sv;
    tsel <= sl;
    lis <= l;
    maxl <= 16'(ml);
    @(posedge clk);
    req <= 1'b0;
    #1 check("busy", 16'(busy), 16'h0001);
    for (int k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk) #1;
    check("done", 16'(done), 16'h0001);
    check("idle", 16'(busy), 16'h0000);
    check("length", rlen, 16'(exp_q.size()));
    check("status", 16'(stat), 16'(st));
    for (int a = 0; a <= exp_q.size() && l; a++) begin
      @(posedge clk);
      raddr <= 16'(a);
      @(posedge clk) #1;
      check("buffer", 16'(rdata), 16'(a < exp_q.size() ? exp_q[a] : 8'h00));
    end
    i_glr_talker.q = {};
    $display("test done length %0d status %h", rlen, stat);
  endtask

  initial begin
    {rst, req, tsv, lis, tset} = 5'h1F;
    {req, tsv, tset} = 3'h0;
    {maxl, raddr, tsel, tslot, gap, tchar} = '0;
    term_tab = '{8'h0A, 8'h0D, 8'h2C, 8'h3B};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    check("not ready", 16'(nrfd), 16'h0001);
    check("not accepted", 16'(ndac), 16'h0001);
    check("reset busy", 16'(busy), 16'h0000);
    // Every slot, when picked, ends a stream; defaulted runs end only on slot 0
    for (int s = 0; s < 8; s++) begin
      gen(6);
      strm.push_back({1'b0, term_tab[s % 4]});
      run(s < 4, 2'(s), 1'b1, 40);
    end
    strm = '{9'h141, 9'h042};
    run(1'b1, 2'd0, 1'b1, 40);
    strm = '{9'h041, 9'h042, 9'h043, 9'h044};
    run(1'b1, 2'd0, 1'b1, 3);
    strm = '{9'h041, 9'h042, 9'h143};
    run(1'b1, 2'd0, 1'b1, 3);
    run(1'b1, 2'd0, 1'b0, 40);
    // Zero length stores only the null
    strm = '{9'h041};
    run(1'b1, 2'd0, 1'b1, 0);
    strm = '{9'h041, 9'h042};
    run(1'b1, 2'd0, 1'b1, 40);
    set_term(2'd2, 8'h21);
    strm = '{9'h041, 9'h02C, 9'h00D, 9'h021};
    run(1'b1, 2'd2, 1'b1, 40);
    // Random streams with a slow or prompt talker
    repeat (30) begin
      gap <= 2'($random(seed));
      gen(12);
      run(1'($random(seed)), 2'($random(seed)),
          ($random(seed) & 7) != 0, 1 + ($random(seed) & 7));
    end
    final_report();
  end
endmodule // gpib_listener_string_receive_tb
`default_nettype wire
